// File: src/bof_pkg.sv
package bof_pkg;
   // Register byte address on the AHB-Lite slave
   localparam logic [7:0] BOF_OPT_ADDR = 8'h20;
   localparam logic [7:0] BOF_CTL_ADDR = 8'h00;
   localparam logic [7:0] BOF_REQ_ADDR = 8'h04;
   localparam logic [7:0] BOF_STAT_ADDR = 8'h08;
   localparam logic [7:0] BOF_ROM_ADDR = 8'h0C;
   // Field positions inside the options word and the control word
   localparam int BOF_ISC_BIT = 29;
   localparam int BOF_BMC_BIT = 28;
   localparam int BOF_PMC_BIT = 27;
   localparam int BOF_ACC_LSB = 16;
   localparam int BOF_REC_LSB = 12;
   localparam int BOF_GEN_LSB = 6;
   localparam int BOF_LINK_ON_BIT = 17;
   // Writable bits and fixed bits
   localparam logic [31:0] BOF_RW_MASK = 32'hF8FF_F0C0;
   localparam logic [31:0] BOF_FIXED = 32'h0000_0002;
   localparam logic [2:0] BOF_LINK_SPEED = 3'h2;
   localparam logic [3:0] BOF_REC_RESET = 4'hA;
   localparam logic [3:0] BOF_REC_MIN = 4'h8;
   localparam logic [31:0] BOF_OPT_RESET = 32'h0000_A002;
   // Acknowledge codes
   localparam logic [1:0] BOF_ACK_OK = 2'h0;
   localparam logic [1:0] BOF_ACK_TYPE_ERR = 2'h1;
   typedef enum logic [1:0] {BOF_IDLE = 2'b00, BOF_DATA_W = 2'b01, BOF_DATA_R = 2'b11} bof_phase_e;
   // Byte limit from a maximum request code
   function automatic logic [16:0] bof_rec_bytes(input logic [3:0] code);
      bof_rec_bytes = 17'h0_0001 << (5'(code) + 5'h01);
   endfunction
endpackage

// File: src/bof_rom_port.sv
`timescale 1ns/100ps
`default_nettype none
// Remote configuration ROM read port: quadlet 1 of the bus info block
module bof_rom_port (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rom_rd,
   input wire logic [1:0] rom_quadlet,
   input wire logic [31:0] opt_word,
   output logic [31:0] rom_data,
   output logic rom_valid
);
   logic [31:0] next_rom_data;
   logic next_rom_valid;
   // Options quadlet answers index 1, others read zero here
   always_comb begin
      next_rom_valid = rom_rd;
      next_rom_data = rom_data;
      if (rom_rd) begin
         next_rom_data = (rom_quadlet == 2'h1) ? opt_word : 32'h0000_0000;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rom_data <= 32'h0000_0000;
         rom_valid <= 1'b0;
      end else begin
         rom_data <= next_rom_data;
         rom_valid <= next_rom_valid;
      end
   end
endmodule // bof_rom_port
`default_nettype wire

// File: src/bof_regs.sv
// What this block does
// - Bit 27 advertises power management capability
// - Bits 26 to 24 read zero
// - Bits 23 to 16 hold clock accuracy
// - Request limit is two to code plus one
// - Oversize block write gets type error ack
// - Request code survives soft reset, 2048 hard
// - Bits 11 to 8 read zero
// - Bits 5 to 3 read zero
// - Link speed bits always read 010
// - Options word is bus info quadlet one
`timescale 1ns/100ps
`default_nettype none
module bof_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic soft_reset,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic blk_wr_req,
   input wire logic [16:0] blk_wr_len,
   output logic [1:0] blk_ack,
   output logic blk_ack_valid,
   input wire logic rom_rd,
   input wire logic [1:0] rom_quadlet,
   output logic [31:0] rom_data,
   output logic rom_valid,
   output logic [31:0] opt_word,
   output logic link_on_control
);
   ////////////////////////////////////////////////////////////////////////
   bof_pkg::bof_phase_e phase, next_phase;
   logic [7:0] daddr, next_daddr;
   logic [31:0] opt_rw, next_opt_rw;
   logic [31:0] ctl, next_ctl;
   logic [31:0] next_hrdata;
   logic [1:0] next_blk_ack;
   logic next_blk_ack_valid;
   logic [15:0] err_cnt, next_err_cnt;
   logic [31:0] opt_view;
   logic [16:0] limit;

   // Assembled word: writable bits plus constant link speed
   assign opt_view = (opt_rw & bof_pkg::BOF_RW_MASK) | bof_pkg::BOF_FIXED;
   assign limit = bof_pkg::bof_rec_bytes(opt_rw[bof_pkg::BOF_REC_LSB +: 4]);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign link_on_control = ctl[bof_pkg::BOF_LINK_ON_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Bus phase tracking and register updates
   always_comb begin
      next_phase = bof_pkg::BOF_IDLE;
      next_daddr = daddr;
      next_opt_rw = opt_rw;
      next_ctl = ctl;
      next_hrdata = hrdata;
      if (phase == bof_pkg::BOF_DATA_W) begin
         unique case (daddr)
            bof_pkg::BOF_OPT_ADDR: next_opt_rw = hwdata & bof_pkg::BOF_RW_MASK;
            bof_pkg::BOF_CTL_ADDR: next_ctl = hwdata & (32'h0000_0001 << bof_pkg::BOF_LINK_ON_BIT);
            default: next_ctl = ctl;
         endcase
      end
      if (hsel && hready && htrans[1]) begin
         next_daddr = haddr[7:0];
         next_phase = hwrite ? bof_pkg::BOF_DATA_W : bof_pkg::BOF_DATA_R;
         if (!hwrite) begin
            unique case (haddr[7:0])
               bof_pkg::BOF_OPT_ADDR: next_hrdata = opt_view;
               bof_pkg::BOF_CTL_ADDR: next_hrdata = ctl;
               bof_pkg::BOF_REQ_ADDR: next_hrdata = {15'h0000, limit};
               bof_pkg::BOF_STAT_ADDR: next_hrdata = {16'h0000, err_cnt};
               bof_pkg::BOF_ROM_ADDR: next_hrdata = opt_view;
               default: next_hrdata = 32'h0000_0000;
            endcase
         end
      end
      // Soft reset clears software fields but keeps request code
      if (soft_reset) begin
         next_opt_rw = opt_rw & (32'h0000_000F << bof_pkg::BOF_REC_LSB);
         next_ctl = 32'h0000_0000;
      end
   end

   // Oversize block write check
   always_comb begin
      next_blk_ack_valid = blk_wr_req;
      next_blk_ack = blk_ack;
      next_err_cnt = err_cnt;
      if (blk_wr_req) begin
         if (blk_wr_len > limit) begin
            next_blk_ack = bof_pkg::BOF_ACK_TYPE_ERR;
            next_err_cnt = err_cnt + 16'h0001;
         end else begin
            next_blk_ack = bof_pkg::BOF_ACK_OK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase <= bof_pkg::BOF_IDLE;
         daddr <= 8'h00;
         opt_rw <= bof_pkg::BOF_OPT_RESET;
         ctl <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
         blk_ack <= bof_pkg::BOF_ACK_OK;
         blk_ack_valid <= 1'b0;
         err_cnt <= 16'h0000;
         opt_word <= bof_pkg::BOF_FIXED;
      end else begin
         phase <= next_phase;
         daddr <= next_daddr;
         opt_rw <= next_opt_rw;
         ctl <= next_ctl;
         hrdata <= next_hrdata;
         blk_ack <= next_blk_ack;
         blk_ack_valid <= next_blk_ack_valid;
         err_cnt <= next_err_cnt;
         opt_word <= opt_view;
      end
   end

   // Remote read path of the bus info block
   bof_rom_port u_rom (
      .clk(clk),
      .rst_n(rst_n),
      .rom_rd(rom_rd),
      .rom_quadlet(rom_quadlet),
      .opt_word(opt_view),
      .rom_data(rom_data),
      .rom_valid(rom_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks
   fixed_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
      (opt_view[26:24] == 3'h0) && (opt_view[11:8] == 4'h0) && (opt_view[5:3] == 3'h0))
      else $error("reserved bits not zero");
   link_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
      phase == bof_pkg::BOF_DATA_R && daddr == bof_pkg::BOF_OPT_ADDR |-> hrdata[2:0] == bof_pkg::BOF_LINK_SPEED)
      else $error("link speed wrong");
   rec_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      soft_reset |=> opt_rw[15:12] == $past(opt_rw[15:12]))
      else $error("request code lost on soft reset");
   rec_reset_a: assert property (@(posedge clk)
      !rst_n |=> opt_rw[15:12] == bof_pkg::BOF_REC_RESET)
      else $error("request code reset wrong");
   type_err_a: assert property (@(posedge clk) disable iff (!rst_n)
      blk_wr_req && blk_wr_len > limit && !(phase == bof_pkg::BOF_DATA_W) |=> blk_ack_valid && blk_ack == bof_pkg::BOF_ACK_TYPE_ERR)
      else $error("oversize write not refused");
   opt_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      phase == bof_pkg::BOF_DATA_W && daddr == bof_pkg::BOF_OPT_ADDR && !soft_reset
      |=> opt_view == (($past(hwdata) & bof_pkg::BOF_RW_MASK) | bof_pkg::BOF_FIXED))
      else $error("options write wrong");
   rom_view_a: assert property (@(posedge clk) disable iff (!rst_n)
      rom_rd && rom_quadlet == 2'h1 |=> rom_valid && rom_data == $past(opt_view))
      else $error("rom quadlet wrong");
   limit_calc_a: assert property (@(posedge clk) disable iff (!rst_n)
      opt_rw[15:12] == bof_pkg::BOF_REC_RESET |-> limit == 17'h0_0800)
      else $error("byte limit wrong");
   opt_wr_c: cover property (@(posedge clk) disable iff (!rst_n) phase == bof_pkg::BOF_DATA_W && daddr == bof_pkg::BOF_OPT_ADDR);
   opt_rd_c: cover property (@(posedge clk) disable iff (!rst_n) phase == bof_pkg::BOF_DATA_R && daddr == bof_pkg::BOF_OPT_ADDR);
   err_c: cover property (@(posedge clk) disable iff (!rst_n) blk_ack_valid && blk_ack == bof_pkg::BOF_ACK_TYPE_ERR);
   soft_c: cover property (@(posedge clk) disable iff (!rst_n) soft_reset);
endmodule // bof_regs
`default_nettype wire

// File: tb/test_bof_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_bof_regs;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic soft_reset = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic hsel = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rom_data, opt_word, rd;
   logic hreadyout, hresp, blk_ack_valid, rom_valid, link_on_control;
   logic blk_wr_req = 1'b0;
   logic [16:0] blk_wr_len = 17'h0_0000;
   logic [1:0] blk_ack;
   logic rom_rd = 1'b0;
   logic [1:0] rom_quadlet = 2'h0;
   int fail_count = 0;
   int checks_done = 0;

   // Device under test, the only slave so its ready is the bus ready
   bof_regs i_dut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .blk_wr_req(blk_wr_req), .blk_wr_len(blk_wr_len),
      .blk_ack(blk_ack), .blk_ack_valid(blk_ack_valid), .rom_rd(rom_rd), .rom_quadlet(rom_quadlet),
      .rom_data(rom_data), .rom_valid(rom_valid), .opt_word(opt_word), .link_on_control(link_on_control));

   // 200 MHz clock
   always #2.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite single word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0000_0000);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask

   // Block write length check: acknowledge one cycle after the request
   task automatic blk(input logic [16:0] len, input logic [1:0] exp);
      @(posedge clk);
      blk_wr_req <= 1'b1;
      blk_wr_len <= len;
      @(posedge clk);
      blk_wr_req <= 1'b0;
      @(posedge clk);
      check({29'h0, blk_ack_valid, blk_ack}, {29'h0, 1'b1, exp});
   endtask

   // Remote configuration ROM read of one bus info quadlet
   task automatic rom(input logic [1:0] q, input logic [31:0] exp);
      @(posedge clk);
      rom_rd <= 1'b1;
      rom_quadlet <= q;
      @(posedge clk);
      rom_rd <= 1'b0;
      @(posedge clk);
      check(rom_data, exp);
      check({31'h0, rom_valid}, 32'h0000_0001);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'h0000_A002);
      ahb(1'b1, bof_pkg::BOF_OPT_ADDR, 32'hFFFF_FFFF);
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'hF8FF_F0C2);
      rom(2'h1, 32'hF8FF_F0C2);
      rom(2'h0, 32'h0000_0000);
      check(opt_word, 32'hF8FF_F0C2);
      ahb(1'b1, bof_pkg::BOF_OPT_ADDR, 32'h0000_0000);
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'h0000_0002);
      ahb(1'b1, bof_pkg::BOF_OPT_ADDR, 32'h0815_8040);
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'h0815_8042);
      blk(17'h0_0200, bof_pkg::BOF_ACK_OK);
      blk(17'h0_0201, bof_pkg::BOF_ACK_TYPE_ERR);
      rd_chk(bof_pkg::BOF_REQ_ADDR, 32'h0000_0200);
      rd_chk(bof_pkg::BOF_STAT_ADDR, 32'h0000_0001);
      rd_chk(bof_pkg::BOF_ROM_ADDR, 32'h0815_8042);
      ahb(1'b1, bof_pkg::BOF_OPT_ADDR, 32'h1000_8000);
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'h1000_8002);
      ahb(1'b1, bof_pkg::BOF_CTL_ADDR, 32'h0002_0000);
      @(posedge clk);
      check({31'h0, link_on_control}, 32'h0000_0001);
      ahb(1'b1, bof_pkg::BOF_OPT_ADDR, 32'hFFFF_FFFF);
      @(posedge clk);
      soft_reset <= 1'b1;
      @(posedge clk);
      soft_reset <= 1'b0;
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'h0000_F002);
      blk(17'h1_0000, bof_pkg::BOF_ACK_OK);
      blk(17'h1_0001, bof_pkg::BOF_ACK_TYPE_ERR);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(bof_pkg::BOF_OPT_ADDR, 32'h0000_A002);
      blk(17'h0_0800, bof_pkg::BOF_ACK_OK);
      blk(17'h0_0801, bof_pkg::BOF_ACK_TYPE_ERR);
      rd_chk(8'h10, 32'h0000_0000);
      stop_test();
   end

   // Watchdog against a hung handshake
   initial begin
      #20000;
      fail_count++;
      stop_test();
   end
endmodule // test_bof_regs
`default_nettype wire
